// ==== sim/fslc_flash_model.sv ====
// Behavioural flash device that answers suspend, resume, lock and status commands.
`timescale 1ns/1ps
module fslc_flash_model #(
    parameter int BUSY_NS = 400
) (
    input  wire logic [19:0] flash_addr,
    input  wire logic [7:0]  dq_o,
    input  wire logic        dq_oe,
    output logic      [7:0]  dq_i,
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic        reset_powerdown_pin_n,
    input  wire logic        rp_override_en,
    input  wire logic        vpp_en,
    output logic             ready_busy_out,
    input  wire logic        start_prog,
    output logic      [16:0] lock_bits
);
    logic [7:0]  sr = 8'h80;
    logic [7:0]  e;
    logic [7:0]  last = 8'h00;
    logic [15:0] blk = 16'h0000; // Pin resets never touch these cells.
    logic        master = 1'b0;
    logic        setup = 1'b0;
    logic        arr = 1'b0;
    logic        susp = 1'b0;
    assign ready_busy_out = sr[7];
    assign lock_bits = {master, blk};
    // No pull resistor on the bus, so a released bus shows the inverse of the last byte.
    assign dq_i = (!ce_n && !oe_n) ? (arr ? flash_addr[7:0] ^ 8'h5a : sr) : ~last;
    always @(dq_i) if (!oe_n) last = dq_i;
    // A program into a locked block is refused unless the reset pin sits at the override level.
    always @(posedge start_prog) sr = (blk[flash_addr[19:16]] && !rp_override_en) ? 8'h92 : 8'h00;
    always @(posedge we_n) begin
        if (!ce_n && reset_powerdown_pin_n && dq_oe) begin
            arr = 1'b0;
            if (setup) begin
                setup = 1'b0;
                e = sr & 8'h3a;
                sr = 8'h00;
                if (dq_o == 8'h01 || dq_o == 8'hf1) begin
                    if (!vpp_en) sr <= #BUSY_NS e | 8'h98;
                    else if (dq_o == 8'hf1 ? !rp_override_en : master && !rp_override_en) sr <= #BUSY_NS e | 8'h92;
                    else begin
                        sr <= #BUSY_NS e | 8'h80;
                        if (dq_o == 8'hf1) master <= #BUSY_NS 1'b1;
                        else blk[flash_addr[19:16]] <= #BUSY_NS 1'b1;
                    end
                end else if (dq_o == 8'hd0) begin
                    if (!vpp_en) sr <= #BUSY_NS e | 8'ha8;
                    else if (master && !rp_override_en) sr <= #BUSY_NS e | 8'ha2;
                    else begin
                        sr <= #BUSY_NS e | 8'h80;
                        blk <= #BUSY_NS 16'h0000; // Master bit is never cleared here.
                    end
                end else sr <= #BUSY_NS e | 8'hb0;
            end else case (dq_o)
                8'h60: if (!susp) setup = 1'b1;
                8'h50: if (!susp) sr = sr & 8'hc5;
                8'hff: arr = 1'b1;
                8'hb0: if (!sr[7]) begin susp = 1'b1; sr <= #BUSY_NS 8'h84; end
                8'hd0: if (susp) begin susp = 1'b0; sr = 8'h00; sr <= #BUSY_NS 8'h80; end
                default: ;
            endcase
        end
    end
endmodule

// ==== sim/tb.sv ====
// Self-checking bench for the flash suspend and lock controller.
`timescale 1ns/1ps
module tb;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] r;
    logic        hready;
    logic        hresp;
    logic [19:0] flash_addr;
    logic [7:0]  dq_o;
    logic [7:0]  dq_i;
    logic        dq_oe, ce_n, we_n, oe_n, rp_n, rp_ov, vpp_en, rb;
    logic        start_prog = 1'b0;
    logic [16:0] lock_bits;
    logic [15:0] lfsr = 16'h0012;
    logic [15:0] mb = 16'h0000;
    logic        mm = 1'b0;
    logic        vpp = 1'b0;
    logic        ov = 1'b0;
    int          err_count = 0;
    int          n_tests = 0;
    int          cyc = 0;

    always #4 clk_sys = ~clk_sys;

    fslc_ctrl fslc_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
        .hrdata(hrdata), .flash_addr(flash_addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .ce_n(ce_n),
        .we_n(we_n), .oe_n(oe_n), .reset_powerdown_pin_n(rp_n), .rp_override_en(rp_ov), .vpp_en(vpp_en),
        .ready_busy_out(rb));
    fslc_flash_model #(.BUSY_NS(800)) fslc_flash_model_i (.flash_addr(flash_addr), .dq_o(dq_o),
        .dq_oe(dq_oe), .dq_i(dq_i), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .reset_powerdown_pin_n(rp_n),
        .rp_override_en(rp_ov), .vpp_en(vpp_en), .ready_busy_out(rb), .start_prog(start_prog),
        .lock_bits(lock_bits));

    task report_and_stop;
        if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            report_and_stop;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] t;
        bus(1'b1, a, d, t);
    endtask

    // Polls the status word until the controller has finished its sequence.
    task automatic op_run(input logic [2:0] op);
        wr(32'h8, {29'h0, op});
        do bus(1'b0, 32'hc, 32'h0, r); while (r[0] !== 1'b0);
    endtask

    task automatic cfg(input logic v, input logic o);
        vpp = v;
        ov = o;
        wr(32'h0, {30'h0, v, o});
    endtask

    task automatic lock_op(input logic [2:0] op, input logic [3:0] b);
        logic [7:0] e;
        e = 8'h80;
        if (!vpp) e = op == 3'h6 ? 8'ha8 : 8'h98;
        else if (op == 3'h5 ? !ov : mm && !ov) e = op == 3'h6 ? 8'ha2 : 8'h92;
        else if (op == 3'h4) mb[b] = 1'b1;
        else if (op == 3'h5) mm = 1'b1;
        else mb = 16'h0000;
        lfsr = lfsr_next(lfsr);
        wr(32'h4, {12'h0, b, lfsr});
        op_run(op);
        chk(r[15:8], e);
        chk(lock_bits, {mm, mb});
        op_run(3'h0);
        chk(r[15:8], 8'h80);
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        bus(1'b0, 32'h0, 32'h0, r);
        chk(r, 32'h0);
        bus(1'b0, 32'h10, 32'h0, r);
        chk(r, 32'h0);
        bus(1'b0, 32'hc, 32'h0, r);
        chk(r[4:0], 5'h10);
        lock_op(3'h4, 4'h3);
        cfg(1'b1, 1'b0);
        lock_op(3'h4, 4'h3);
        lock_op(3'h5, 4'h0);
        lock_op(3'h6, 4'h0);
        lock_op(3'h4, 4'h5);
        cfg(1'b1, 1'b1);
        lock_op(3'h5, 4'h0);
        cfg(1'b1, 1'b0);
        lock_op(3'h4, 4'h7);
        lock_op(3'h6, 4'h0);
        cfg(1'b1, 1'b1);
        lock_op(3'h4, 4'h7);
        lock_op(3'h4, 4'hf);
        lock_op(3'h6, 4'h0);
        cfg(1'b0, 1'b0);
        lock_op(3'h6, 4'h0);
        cfg(1'b1, 1'b0);
        // A program already running in the device is the thing that gets suspended.
        start_prog <= 1'b1;
        repeat (6) @(posedge clk_sys);
        op_run(3'h2);
        chk(r[15:8], 8'h84);
        chk(r[4:1], 4'h9);
        wr(32'h8, 32'h4);
        repeat (4) @(posedge clk_sys);
        bus(1'b0, 32'hc, 32'h0, r);
        chk(r[2], 1'b1);
        wr(32'hc, 32'h4);
        bus(1'b0, 32'hc, 32'h0, r);
        chk(r[2], 1'b0);
        lfsr = lfsr_next(lfsr);
        wr(32'h4, {16'h0, lfsr});
        op_run(3'h7);
        chk(r[23:16], lfsr[7:0] ^ 8'h5a);
        op_run(3'h3);
        op_run(3'h0);
        chk(r[15:8], 8'h00);
        chk(r[1], 1'b0);
        start_prog <= 1'b0;
        repeat (120) @(posedge clk_sys);
        op_run(3'h1);
        op_run(3'h0);
        chk(r[15:8], 8'h80);
        // A flash reset pulse cuts a lock clear in its setup write; locks must survive it.
        wr(32'h8, 32'h6);
        wr(32'h0, 32'h6);
        cfg(1'b1, 1'b1);
        bus(1'b0, 32'hc, 32'h0, r);
        chk(r[3:0], 4'h8);
        chk(lock_bits, {mm, mb});
        lock_op(3'h6, 4'h0);
        chk(r[3], 1'b0);
        report_and_stop;
    end
endmodule

// ==== verilog/fslc_ctrl.sv ====
// Host-side controller that issues suspend, resume and lock commands to the flash over its pins.
//
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module fslc_ctrl #(
    parameter logic [7:0] CMD_SUSPEND     = 8'hb0,
    parameter logic [7:0] CMD_RESUME      = 8'hd0,
    parameter logic [7:0] CMD_CLR_CONFIRM = 8'hd0
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic [19:0]      flash_addr,
    output logic [7:0]       dq_o,
    output logic             dq_oe,
    input  wire logic [7:0]  dq_i,
    output logic             ce_n,
    output logic             we_n,
    output logic             oe_n,
    output logic             reset_powerdown_pin_n,
    output logic             rp_override_en,
    output logic             vpp_en,
    input  wire logic        ready_busy_out
);
    fslc_pkg::fslc_state_e state_q;
    fslc_pkg::fslc_op_e    op_q;
    fslc_pkg::fslc_op_e    op_in;
    logic [4:0]  cnt_q;
    logic [2:0]  ctrl_q;
    logic [19:0] addr_q, faddr_q;
    logic [7:0]  dq_q, rd_q, status_q, data_q;
    logic [7:0]  dq_s1_q, dq_s2_q, dq_s3_q, dq_f_q;
    logic [2:0]  rb_s_q;
    logic        rb_q;
    logic        ce_n_q, we_n_q, oe_n_q, dq_oe_q;
    logic        suspended_q, refused_q, unknown_q;
    logic        wr_pend_q;
    logic [3:0]  wofs_q;
    logic [31:0] hrdata_q;
    logic        addr_ok, start, start_ok, w_end, r_end, in_write, abort;

    function automatic logic lock_op(input fslc_pkg::fslc_op_e op);
        return op inside {fslc_pkg::OP_SET_BLOCK, fslc_pkg::OP_SET_MASTER, fslc_pkg::OP_CLR_LOCKS};
    endfunction

    function automatic logic polls(input fslc_pkg::fslc_op_e op);
        return lock_op(op) || op == fslc_pkg::OP_SUSPEND;
    endfunction

    function automatic logic err_bits(input logic [7:0] sr);
        return sr[fslc_pkg::SR_CLRE] | sr[fslc_pkg::SR_SETE] | sr[fslc_pkg::SR_SUPP] | sr[fslc_pkg::SR_PROT];
    endfunction

    function automatic logic [7:0] first_cmd(input fslc_pkg::fslc_op_e op);
        case (op)
            fslc_pkg::OP_CLR_STATUS: return fslc_pkg::CMD_CLR_STATUS;
            fslc_pkg::OP_SUSPEND:    return CMD_SUSPEND;
            fslc_pkg::OP_RESUME:     return CMD_RESUME;
            fslc_pkg::OP_RD_ARRAY:   return fslc_pkg::CMD_RD_ARRAY;
            fslc_pkg::OP_RD_STATUS:  return fslc_pkg::CMD_RD_STATUS;
            default:                 return fslc_pkg::CMD_LOCK_SETUP;
        endcase
    endfunction

    function automatic logic [7:0] second_cmd(input fslc_pkg::fslc_op_e op);
        case (op)
            fslc_pkg::OP_SET_BLOCK:  return fslc_pkg::CMD_SET_BLOCK;
            fslc_pkg::OP_SET_MASTER: return fslc_pkg::CMD_SET_MASTER;
            default:                 return CMD_CLR_CONFIRM;
        endcase
    endfunction

    // The slave never stalls: every access completes with no wait state.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;
    assign addr_ok   = hsel && hready && htrans[1] && hsize == 3'h2;
    assign op_in     = fslc_pkg::fslc_op_e'(hwdata[2:0]);
    assign start     = wr_pend_q && wofs_q == fslc_pkg::OFS_CMD;
    assign abort     = ctrl_q[fslc_pkg::CTRL_RST_BIT];
    // During a suspend only status read, array read and resume are passed on.
    assign start_ok  = start && state_q == fslc_pkg::S_IDLE && !abort &&
                       (!suspended_q || op_in inside {fslc_pkg::OP_RD_STATUS, fslc_pkg::OP_RD_ARRAY,
                                                      fslc_pkg::OP_RESUME});
    assign in_write  = state_q inside {fslc_pkg::S_W1, fslc_pkg::S_W2, fslc_pkg::S_CLR};
    assign w_end     = in_write && cnt_q == fslc_pkg::W_LAST;
    assign r_end     = state_q == fslc_pkg::S_RD && cnt_q == fslc_pkg::R_LAST;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            wofs_q    <= 4'h0;
            hrdata_q  <= 32'h00000000;
        end else begin
            wr_pend_q <= addr_ok && hwrite && haddr[31:4] == 28'h0000000;
            wofs_q    <= haddr[3:0];
            if (addr_ok && !hwrite) begin
                case (haddr[31:0] & 32'hffff_fffc)
                    32'(fslc_pkg::OFS_CTRL): hrdata_q <= {29'h0, ctrl_q};
                    32'(fslc_pkg::OFS_ADDR): hrdata_q <= {12'h000, addr_q};
                    32'(fslc_pkg::OFS_CMD):  hrdata_q <= {29'h0, op_q};
                    32'(fslc_pkg::OFS_STAT): hrdata_q <= {8'h00, data_q, status_q, 3'h0, rb_q, unknown_q,
                                                          refused_q, suspended_q, state_q != fslc_pkg::S_IDLE};
                    default:                 hrdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_q <= fslc_pkg::CTRL_RESET;
            addr_q <= fslc_pkg::ADDR_RESET;
        end else if (wr_pend_q) begin
            if (wofs_q == fslc_pkg::OFS_CTRL) ctrl_q <= hwdata[2:0];
            if (wofs_q == fslc_pkg::OFS_ADDR) addr_q <= hwdata[19:0];
        end
    end

    // A level counts once the second and third stage agree.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dq_s1_q <= 8'h00;
            dq_s2_q <= 8'h00;
            dq_s3_q <= 8'h00;
            dq_f_q  <= 8'h00;
            rb_s_q  <= 3'h0;
            rb_q    <= 1'b0;
        end else begin
            dq_s1_q <= dq_i;
            dq_s2_q <= dq_s1_q;
            dq_s3_q <= dq_s2_q;
            dq_f_q  <= (dq_s2_q & dq_s3_q) | (dq_f_q & (dq_s2_q | dq_s3_q));
            rb_s_q  <= {rb_s_q[1:0], ready_busy_out};
            if (rb_s_q[1] == rb_s_q[2]) rb_q <= rb_s_q[2];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n || abort) begin
            state_q <= fslc_pkg::S_IDLE;
            cnt_q   <= 5'h00;
            if (!rst_n) op_q <= fslc_pkg::OP_RD_STATUS;
        end else begin
            cnt_q <= cnt_q + 5'h01;
            case (state_q)
                fslc_pkg::S_IDLE: begin
                    cnt_q <= 5'h00;
                    if (start_ok) begin
                        state_q <= fslc_pkg::S_W1;
                        op_q    <= op_in;
                    end
                end
                fslc_pkg::S_W1: begin
                    if (w_end) begin
                        cnt_q <= 5'h00;
                        if (lock_op(op_q)) state_q <= fslc_pkg::S_W2;
                        else if (op_q inside {fslc_pkg::OP_RESUME, fslc_pkg::OP_CLR_STATUS})
                            state_q <= fslc_pkg::S_IDLE;
                        else state_q <= fslc_pkg::S_RD;
                    end
                end
                fslc_pkg::S_W2: begin
                    if (w_end) begin
                        cnt_q   <= 5'h00;
                        state_q <= fslc_pkg::S_RD;
                    end
                end
                fslc_pkg::S_RD: begin
                    if (r_end) begin
                        cnt_q <= 5'h00;
                        // Status bits below the ready flag are not trusted until it reads 1.
                        if (polls(op_q) && !rd_q[fslc_pkg::SR_READY]) state_q <= fslc_pkg::S_RD;
                        else if (lock_op(op_q) && err_bits(rd_q)) state_q <= fslc_pkg::S_CLR;
                        else state_q <= fslc_pkg::S_IDLE;
                    end
                end
                fslc_pkg::S_CLR: begin
                    if (w_end) state_q <= fslc_pkg::S_IDLE;
                end
                default: state_q <= fslc_pkg::S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dq_q    <= 8'h00;
            faddr_q <= 20'h00000;
        end else if (start_ok) begin
            dq_q    <= first_cmd(op_in);
            faddr_q <= addr_q;
        end else if (state_q == fslc_pkg::S_W1 && w_end) begin
            dq_q <= second_cmd(op_q);
        end else if (r_end) begin
            dq_q <= fslc_pkg::CMD_CLR_STATUS;
        end
    end

    // Strobes are registered so the pins never glitch; they trail the counter by one cycle.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ce_n_q  <= 1'b1;
            we_n_q  <= 1'b1;
            oe_n_q  <= 1'b1;
            dq_oe_q <= 1'b0;
        end else begin
            ce_n_q  <= state_q == fslc_pkg::S_IDLE;
            we_n_q  <= !(in_write && cnt_q < fslc_pkg::WE_CYC);
            oe_n_q  <= !(state_q == fslc_pkg::S_RD && cnt_q < fslc_pkg::R_SAMPLE);
            dq_oe_q <= in_write;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_q     <= 8'h00;
            status_q <= 8'h00;
            data_q   <= 8'h00;
        end else begin
            if (state_q == fslc_pkg::S_RD && cnt_q == fslc_pkg::R_SAMPLE) rd_q <= dq_f_q;
            if (r_end && op_q == fslc_pkg::OP_RD_ARRAY) data_q <= rd_q;
            else if (r_end) status_q <= rd_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            suspended_q <= 1'b0;
            refused_q   <= 1'b0;
            unknown_q   <= 1'b0;
        end else begin
            if (r_end && op_q == fslc_pkg::OP_SUSPEND && rd_q[fslc_pkg::SR_READY])
                suspended_q <= rd_q[fslc_pkg::SR_PSUSP];
            else if (w_end && state_q == fslc_pkg::S_W1 && op_q == fslc_pkg::OP_RESUME)
                suspended_q <= 1'b0;
            // A refusal in the same cycle as its clear is kept.
            if (start && !start_ok) refused_q <= 1'b1;
            else if (wr_pend_q && wofs_q == fslc_pkg::OFS_STAT && hwdata[fslc_pkg::ST_REFUSED_BIT]) refused_q <= 1'b0;
            if (abort && state_q != fslc_pkg::S_IDLE && op_q == fslc_pkg::OP_CLR_LOCKS) unknown_q <= 1'b1;
            else if (r_end && op_q == fslc_pkg::OP_CLR_LOCKS && rd_q[fslc_pkg::SR_READY] && !err_bits(rd_q))
                unknown_q <= 1'b0;
        end
    end

    assign flash_addr            = faddr_q;
    assign dq_o                  = dq_q;
    assign dq_oe                 = dq_oe_q;
    assign ce_n                  = ce_n_q;
    assign we_n                  = we_n_q;
    assign oe_n                  = oe_n_q;
    assign reset_powerdown_pin_n = !ctrl_q[fslc_pkg::CTRL_RST_BIT];
    assign rp_override_en        = ctrl_q[fslc_pkg::CTRL_HV_BIT];
    assign vpp_en                = ctrl_q[fslc_pkg::CTRL_VPP_BIT];

    a_we_width: assert property (@(posedge clk_sys) disable iff (!rst_n || abort)
        $fell(we_n) |-> (!we_n)[*7] ##1 we_n) else $error("write strobe width wrong");
    a_master_confirm: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == fslc_pkg::S_W2 && !we_n && op_q == fslc_pkg::OP_SET_MASTER) |-> dq_o == 8'hf1)
        else $error("master confirm code wrong");
    a_poll_busy: assert property (@(posedge clk_sys) disable iff (!rst_n || abort)
        (r_end && polls(op_q) && !rd_q[7]) |=> state_q == fslc_pkg::S_RD && cnt_q == 5'h00)
        else $error("busy status not polled again");
    a_err_clear: assert property (@(posedge clk_sys) disable iff (!rst_n || abort)
        (r_end && lock_op(op_q) && rd_q[7] && (rd_q[4] || rd_q[1])) |=> state_q == fslc_pkg::S_CLR ##1 !we_n)
        else $error("lock error not followed by status clear");
    a_clr_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == fslc_pkg::S_CLR && !we_n) |-> dq_o == 8'h50) else $error("status clear code wrong");
    a_susp_refuse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start && suspended_q && op_in inside {fslc_pkg::OP_SET_BLOCK, fslc_pkg::OP_CLR_LOCKS})
        |=> refused_q && state_q == fslc_pkg::S_IDLE) else $error("command passed during suspend");
    a_resume_flag: assert property (@(posedge clk_sys) disable iff (!rst_n || abort)
        (w_end && state_q == fslc_pkg::S_W1 && op_q == fslc_pkg::OP_RESUME)
        |=> !suspended_q && state_q == fslc_pkg::S_IDLE)
        else $error("suspend flag kept after resume");
    a_suspend_seen: assert property (@(posedge clk_sys) disable iff (!rst_n || abort)
        (r_end && op_q == fslc_pkg::OP_SUSPEND && rd_q[7] && rd_q[2]) |=> suspended_q ##1 $stable(suspended_q))
        else $error("suspend not recorded");
    a_clear_cut: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (abort && state_q != fslc_pkg::S_IDLE && op_q == fslc_pkg::OP_CLR_LOCKS)
        |=> unknown_q && state_q == fslc_pkg::S_IDLE)
        else $error("cut clear not flagged");
    c_suspend: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(suspended_q));
    c_lock_err: cover property (@(posedge clk_sys) disable iff (!rst_n) state_q == fslc_pkg::S_CLR);
    c_clear_ok: cover property (@(posedge clk_sys) disable iff (!rst_n)
        r_end && op_q == fslc_pkg::OP_CLR_LOCKS && rd_q[7] && !err_bits(rd_q));
endmodule

// ==== verilog/fslc_pkg.sv ====
// Constants, command codes, register map and types of the flash suspend and lock controller.
// Overview of operation
// - While suspended only array read, status read and resume may be issued.
// - A lock set is a setup write then a confirm write at block or device address.
// - After a lock set ends, the controller checks the set error and clears status.
// - After a lock clear ends, the controller checks the clear error and clears status.
// - A lock clear cut short by reset leaves locks unknown; it must be repeated.
// - Status bits 6 to 0 are ignored while the ready flag reads 0.
package fslc_pkg;
    localparam int PERIOD_NS = 8;
    localparam int T_WE_NS   = 50;
    localparam int T_OE_NS   = 90;
    localparam int T_REC_NS  = 30;
    localparam logic [4:0] WE_CYC   = 5'((T_WE_NS + PERIOD_NS - 1) / PERIOD_NS);
    localparam logic [4:0] OE_CYC   = 5'((T_OE_NS + PERIOD_NS - 1) / PERIOD_NS);
    localparam logic [4:0] REC_CYC  = 5'((T_REC_NS + PERIOD_NS - 1) / PERIOD_NS);
    localparam logic [4:0] SYNC_CYC = 5'h3;
    localparam logic [4:0] W_LAST   = 5'(WE_CYC + REC_CYC - 5'h1);
    localparam logic [4:0] R_SAMPLE = 5'(OE_CYC + SYNC_CYC);
    localparam logic [4:0] R_LAST   = 5'(OE_CYC + SYNC_CYC + REC_CYC);

    localparam logic [7:0] CMD_RD_ARRAY   = 8'hff;
    localparam logic [7:0] CMD_RD_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_SET_BLOCK  = 8'h01;
    localparam logic [7:0] CMD_SET_MASTER = 8'hf1;

    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_ADDR = 4'h4;
    localparam logic [3:0] OFS_CMD  = 4'h8;
    localparam logic [3:0] OFS_STAT = 4'hc;

    localparam int CTRL_HV_BIT  = 0;
    localparam int CTRL_VPP_BIT = 1;
    localparam int CTRL_RST_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [19:0] ADDR_RESET = 20'h00000;

    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_SUSP_BIT    = 1;
    localparam int ST_REFUSED_BIT = 2;
    localparam int ST_UNKNOWN_BIT = 3;
    localparam int ST_RB_BIT      = 4;
    localparam int ST_SR_LSB      = 8;
    localparam int ST_DATA_LSB    = 16;

    localparam int SR_READY = 7;
    localparam int SR_CLRE  = 5;
    localparam int SR_SETE  = 4;
    localparam int SR_SUPP  = 3;
    localparam int SR_PSUSP = 2;
    localparam int SR_PROT  = 1;

    typedef enum logic [2:0] {
        OP_RD_STATUS, OP_CLR_STATUS, OP_SUSPEND, OP_RESUME,
        OP_SET_BLOCK, OP_SET_MASTER, OP_CLR_LOCKS, OP_RD_ARRAY
    } fslc_op_e;

    typedef enum logic [2:0] {S_IDLE, S_W1, S_W2, S_RD, S_CLR} fslc_state_e;
endpackage
